// File: rtl/settings_cmd_cfg.svh
// Purpose: Constants for the settings-store and status command block.
// Assumes: 32-bit register words, byte addresses on an 8-bit window.
// Notes: Command words are four ASCII letters packed with the first letter in the low byte.
`ifndef SETTINGS_CMD_CFG_SVH
`define SETTINGS_CMD_CFG_SVH

// Register byte offsets.
`define OFS_CMD        8'h00
`define OFS_ANSWER     8'h04
`define OFS_STATE      8'h08
`define OFS_WIND       8'h0c
`define OFS_CTRL       8'h10
`define OFS_BUSY       8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_ENABLE 8'h1c
`define OFS_IRQ_CLEAR  8'h20

// Command words.
`define CMD_SAVE       32'h65766173
`define CMD_READ       32'h64616572
`define CMD_SAVE_CAL   32'h73726173
`define CMD_READ_CAL   32'h73726572
`define CMD_EE_SAVE    32'h76736565
`define CMD_EE_READ    32'h64726565
`define CMD_GETS       32'h73746567
`define CMD_ERROR      32'h63727265

// Field positions and values.
`define CTRL_EE_UNLOCK_BIT 0
`define BUSY_BIT           0
`define LAST_ERR_BIT       1
`define IRQ_DONE_BIT       0
`define IRQ_ERR_BIT        1
`define IRQ_MOTION_BIT     2
`define IRQ_W              3
`define COMMAND_ID_MASK    8'h3f
`define CMD_ACTIVE_FLAG    8'h80
`define CMD_FAILED_FLAG    8'h40
`define POWER_MAX_CODE     8'h05
`define POWER_HOLE_CODE    8'h02
`define ENCODER_MAX_CODE   8'h04
`define ENCODER_UNKNOWN    8'h01

// Reset values.
`define RST_CTRL       32'h00000000
`define RST_IRQ_ENABLE 3'h0
`define RST_ANSWER     32'h00000000

// Bus answers.
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// File: rtl/settings_cmd_pkg.sv
// Purpose: Types shared by the settings-store and status command block.
// Assumes: Nothing beyond the constants header.
// Notes: The operation enum is also the code driven to the storage engine.
package settings_cmd_pkg;

	// Operations that a command word can select.
	typedef enum logic [2:0] {
		op_none,
		op_save,
		op_read,
		op_save_cal,
		op_read_cal,
		op_ee_save,
		op_ee_read,
		op_status
	} nv_op_t;

	// Command sequencer states.
	typedef enum logic [0:0] {
		st_idle,
		st_wait_nv
	} cmd_state_t;

endpackage : settings_cmd_pkg

// File: rtl/settings_cmd_decode.sv
// Purpose: Map a 32-bit command word to an operation.
// Assumes: Purely combinational, used by the command sequencer.
// Notes: Any word not listed decodes to op_none and is answered as an error.
`timescale 1ns/100ps
`default_nettype none
`include "settings_cmd_cfg.svh"

module settings_cmd_decode
(
	input  wire logic [31:0]                 cmd_word,
	output var  settings_cmd_pkg::nv_op_t    op
);

	// Exact match only; partial words never select an operation.
	always_comb
	begin
		case (cmd_word)
			`CMD_SAVE:     op = settings_cmd_pkg::op_save;
			`CMD_READ:     op = settings_cmd_pkg::op_read;
			`CMD_SAVE_CAL: op = settings_cmd_pkg::op_save_cal;
			`CMD_READ_CAL: op = settings_cmd_pkg::op_read_cal;
			`CMD_EE_SAVE:  op = settings_cmd_pkg::op_ee_save;
			`CMD_EE_READ:  op = settings_cmd_pkg::op_ee_read;
			`CMD_GETS:     op = settings_cmd_pkg::op_status;
			default:       op = settings_cmd_pkg::op_none;
		endcase
	end

endmodule : settings_cmd_decode
`default_nettype wire

// File: rtl/settings_cmd_ctrl.sv
// Purpose: Register-driven interpreter for settings store/load and status commands.
// Assumes: Storage engine and motion core are outside; their signals are synchronous.
// Notes: Commands arrive through bus registers; the rules of operation follow.
// Operation
// - Save-all command word is 0x65766173.
// - Save-all copies RAM settings into flash.
// - Command 0x64616572 reloads all settings from flash.
// - Command 0x73726173 saves calibration settings to flash.
// - Command 0x73726572 reloads calibration settings from flash.
// - Command 0x76736565 saves to stage EEPROM, manufacturer only.
// - Command 0x64726565 is the stage EEPROM read.
// - Storage requests are four bytes, answers four.
// - Status query 0x73746567 answers command plus state bytes.
// - Motion byte: moving, target speed, backlash bits.
// - Low six bits name last motion command.
// - Bit 0x80 running, 0x40 error after end.
// - Power byte codes 0,1,3,4,5.
// - Encoder byte codes 0 through 4.
// - Windings: A low nibble, B high nibble.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "settings_cmd_cfg.svh"

module settings_cmd_ctrl
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic                clock,
	input  wire logic                arst_n,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output var  logic                s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output var  logic                s_axi_wready,
	output var  logic [1:0]          s_axi_bresp,
	output var  logic                s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output var  logic                s_axi_arready,
	output var  logic [31:0]         s_axi_rdata,
	output var  logic [1:0]          s_axi_rresp,
	output var  logic                s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output var  logic                nv_req,
	output var  logic [2:0]          nv_op,
	input  wire logic                nv_done,
	input  wire logic                nv_error,
	input  wire logic                motor_moving,
	input  wire logic                target_speed_reached,
	input  wire logic                backlash_active,
	input  wire logic [5:0]          last_command_id,
	input  wire logic                command_running,
	input  wire logic                command_failed,
	input  wire logic [7:0]          power_code,
	input  wire logic [7:0]          encoder_code,
	input  wire logic [1:0]          winding_a_code,
	input  wire logic [1:0]          winding_b_code,
	output var  logic                irq
);

	// The decoder indexes bits 7:2 and refuses any address with a bit set above the low byte; narrower windows are rejected at elaboration.
	if (ADDR_W < 8)
	begin : g_addr_w_check
		$error("ADDR_W must be at least 8");
	end

	logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
	logic [31:0]       wdata_ff, nxt_wdata;
	logic [3:0]        wstrb_ff, nxt_wstrb;
	logic              have_aw_ff, nxt_have_aw, have_w_ff, nxt_have_w;
	logic              awready_ff, nxt_awready, wready_ff, nxt_wready;
	logic              bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
	logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0]       rdata_ff, nxt_rdata;
	logic [31:0]       ctrl_ff, nxt_ctrl;
	logic [`IRQ_W-1:0] enable_ff, nxt_enable, status_ff, nxt_status;
	logic              irq_ff, nxt_irq, run_prev_ff;
	logic              do_write, cmd_go, in_range_w, in_range_r;
	logic [`IRQ_W-1:0] clr;

	settings_cmd_pkg::cmd_state_t state_ff, nxt_state;
	settings_cmd_pkg::nv_op_t     op_dec, op_ff, nxt_op;
	logic [31:0] cmd_word_ff, nxt_cmd_word, answer_ff, nxt_answer, state_word_ff, nxt_state_word;
	logic [7:0]  wind_ff, nxt_wind, power_byte, encoder_byte;
	logic        cmd_go_ff, busy_ff, nxt_busy, last_err_ff, nxt_last_err, nv_req_ff, nxt_nv_req;
	logic        ev_done, ev_err;

	assign in_range_w = (aw_addr_ff >> 8) == '0;
	assign in_range_r = (s_axi_araddr >> 8) == '0;

	// Bus slave: address and data are latched apart, the write lands once both are held.
	always_comb
	begin
		nxt_aw_addr = aw_addr_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb   = wstrb_ff;
		nxt_have_aw = have_aw_ff;
		nxt_have_w  = have_w_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_enable  = enable_ff;
		clr         = '0;
		cmd_go      = 1'b0;
		if (s_axi_awvalid && awready_ff)
		begin
			nxt_aw_addr = s_axi_awaddr;
			nxt_have_aw = 1'b1;
		end
		if (s_axi_wvalid && wready_ff)
		begin
			nxt_wdata  = s_axi_wdata;
			nxt_wstrb  = s_axi_wstrb;
			nxt_have_w = 1'b1;
		end
		do_write = have_aw_ff && have_w_ff && !bvalid_ff;
		if (do_write)
		begin
			nxt_have_aw = 1'b0;
			nxt_have_w  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = `RESP_OKAY;
			case (in_range_w ? {aw_addr_ff[7:2], 2'b00} : 8'hff)
				`OFS_CMD:
				begin
					// A second command while one runs is refused on the bus.
					if (busy_ff || wstrb_ff != 4'hf)
						nxt_bresp = `RESP_SLVERR;
					else
						cmd_go = 1'b1;
				end
				`OFS_CTRL:
				begin
					for (int i = 0; i < 4; i++)
						if (wstrb_ff[i])
							nxt_ctrl[i*8 +: 8] = wdata_ff[i*8 +: 8];
				end
				`OFS_IRQ_ENABLE:
				begin
					if (wstrb_ff[0])
						nxt_enable = wdata_ff[`IRQ_W-1:0];
				end
				`OFS_IRQ_CLEAR:
				begin
					if (wstrb_ff[0])
						clr = wdata_ff[`IRQ_W-1:0];
				end
				`OFS_ANSWER, `OFS_STATE, `OFS_WIND, `OFS_BUSY, `OFS_IRQ_STATUS: ;
				default: nxt_bresp = `RESP_SLVERR;
			endcase
		end
		if (bvalid_ff && s_axi_bready)
			nxt_bvalid = 1'b0;
		nxt_awready = !nxt_have_aw && !nxt_bvalid;
		nxt_wready  = !nxt_have_w && !nxt_bvalid;

		// Reads are answered one cycle after the address is taken.
		nxt_rvalid  = rvalid_ff;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		if (rvalid_ff && s_axi_rready)
			nxt_rvalid = 1'b0;
		if (s_axi_arvalid && arready_ff)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = `RESP_OKAY;
			case (in_range_r ? {s_axi_araddr[7:2], 2'b00} : 8'hff)
				`OFS_CMD, `OFS_IRQ_CLEAR: nxt_rdata = 32'h00000000;
				`OFS_ANSWER:     nxt_rdata = answer_ff;
				`OFS_STATE:      nxt_rdata = state_word_ff;
				`OFS_WIND:       nxt_rdata = {24'h000000, wind_ff};
				`OFS_CTRL:       nxt_rdata = ctrl_ff;
				`OFS_BUSY:       nxt_rdata = {30'h00000000, last_err_ff, busy_ff};
				`OFS_IRQ_STATUS: nxt_rdata = {29'h00000000, status_ff};
				`OFS_IRQ_ENABLE: nxt_rdata = {29'h00000000, enable_ff};
				default:
				begin
					nxt_rdata = 32'h00000000;
					nxt_rresp = `RESP_SLVERR;
				end
			endcase
		end
		nxt_arready = !nxt_rvalid;

		// Set wins over a clear arriving in the same cycle.
		nxt_status = (status_ff & ~clr);
		nxt_status[`IRQ_DONE_BIT]   = nxt_status[`IRQ_DONE_BIT] | ev_done;
		nxt_status[`IRQ_ERR_BIT]    = nxt_status[`IRQ_ERR_BIT] | ev_err;
		nxt_status[`IRQ_MOTION_BIT] = nxt_status[`IRQ_MOTION_BIT] | (run_prev_ff && !command_running);
		nxt_irq = |(status_ff & enable_ff);
	end

	// Bus and interrupt registers.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_addr_ff  <= '0;
			wdata_ff    <= 32'h00000000;
			wstrb_ff    <= 4'h0;
			have_aw_ff  <= 1'b0;
			have_w_ff   <= 1'b0;
			awready_ff  <= 1'b0;
			wready_ff   <= 1'b0;
			bvalid_ff   <= 1'b0;
			bresp_ff    <= `RESP_OKAY;
			arready_ff  <= 1'b0;
			rvalid_ff   <= 1'b0;
			rdata_ff    <= 32'h00000000;
			rresp_ff    <= `RESP_OKAY;
			ctrl_ff     <= `RST_CTRL;
			enable_ff   <= `RST_IRQ_ENABLE;
			status_ff   <= '0;
			irq_ff      <= 1'b0;
			run_prev_ff <= 1'b0;
		end
		else
		begin
			aw_addr_ff  <= nxt_aw_addr;
			wdata_ff    <= nxt_wdata;
			wstrb_ff    <= nxt_wstrb;
			have_aw_ff  <= nxt_have_aw;
			have_w_ff   <= nxt_have_w;
			awready_ff  <= nxt_awready;
			wready_ff   <= nxt_wready;
			bvalid_ff   <= nxt_bvalid;
			bresp_ff    <= nxt_bresp;
			arready_ff  <= nxt_arready;
			rvalid_ff   <= nxt_rvalid;
			rdata_ff    <= nxt_rdata;
			rresp_ff    <= nxt_rresp;
			ctrl_ff     <= nxt_ctrl;
			enable_ff   <= nxt_enable;
			status_ff   <= nxt_status;
			irq_ff      <= nxt_irq;
			run_prev_ff <= command_running;
		end
	end

	settings_cmd_decode u_decode
	(
		.cmd_word (cmd_word_ff),
		.op       (op_dec)
	);

	// Out-of-range codes are reported as unknown rather than passed through.
	assign power_byte   = (power_code > `POWER_MAX_CODE || power_code == `POWER_HOLE_CODE) ? 8'h00 : power_code;
	assign encoder_byte = (encoder_code > `ENCODER_MAX_CODE) ? `ENCODER_UNKNOWN : encoder_code;

	// Command sequencer: one command at a time, storage answers wait for the engine.
	always_comb
	begin
		nxt_state      = state_ff;
		nxt_op         = op_ff;
		nxt_cmd_word   = cmd_go ? wdata_ff : cmd_word_ff;
		nxt_answer     = answer_ff;
		nxt_state_word = state_word_ff;
		nxt_wind       = wind_ff;
		nxt_busy       = busy_ff | cmd_go;
		nxt_last_err   = last_err_ff;
		nxt_nv_req     = nv_req_ff;
		ev_done        = 1'b0;
		ev_err         = 1'b0;
		case (state_ff)
			settings_cmd_pkg::st_idle:
			begin
				if (cmd_go_ff)
				begin
					case (op_dec)
						settings_cmd_pkg::op_none:
						begin
							nxt_answer = `CMD_ERROR;
							ev_err     = 1'b1;
						end
						settings_cmd_pkg::op_status:
						begin
							nxt_answer = cmd_word_ff;
							nxt_state_word = {encoder_byte, power_byte,
								command_running, command_failed & !command_running, last_command_id,
								5'b00000, backlash_active, target_speed_reached, motor_moving};
							nxt_wind = {2'b00, winding_b_code, 2'b00, winding_a_code};
							ev_done  = 1'b1;
						end
						settings_cmd_pkg::op_ee_save:
						begin
							// Stage EEPROM writes stay locked unless factory unlock is set.
							if (ctrl_ff[`CTRL_EE_UNLOCK_BIT])
							begin
								nxt_nv_req = 1'b1;
								nxt_op     = op_dec;
								nxt_state  = settings_cmd_pkg::st_wait_nv;
							end
							else
							begin
								nxt_answer = `CMD_ERROR;
								ev_err     = 1'b1;
							end
						end
						default:
						begin
							nxt_nv_req = 1'b1;
							nxt_op     = op_dec;
							nxt_state  = settings_cmd_pkg::st_wait_nv;
						end
					endcase
				end
			end
			settings_cmd_pkg::st_wait_nv:
			begin
				if (nv_done)
				begin
					nxt_nv_req = 1'b0;
					nxt_answer = nv_error ? `CMD_ERROR : cmd_word_ff;
					ev_err     = nv_error;
					ev_done    = !nv_error;
					nxt_state  = settings_cmd_pkg::st_idle;
				end
			end
			default: nxt_state = settings_cmd_pkg::st_idle;
		endcase
		if (ev_done || ev_err)
		begin
			nxt_busy     = 1'b0;
			nxt_last_err = ev_err;
		end
	end

	// Command sequencer registers.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff      <= settings_cmd_pkg::st_idle;
			op_ff         <= settings_cmd_pkg::op_none;
			cmd_word_ff   <= 32'h00000000;
			answer_ff     <= `RST_ANSWER;
			state_word_ff <= 32'h00000000;
			wind_ff       <= 8'h00;
			busy_ff       <= 1'b0;
			last_err_ff   <= 1'b0;
			nv_req_ff     <= 1'b0;
			cmd_go_ff     <= 1'b0;
		end
		else
		begin
			state_ff      <= nxt_state;
			op_ff         <= nxt_op;
			cmd_word_ff   <= nxt_cmd_word;
			answer_ff     <= nxt_answer;
			state_word_ff <= nxt_state_word;
			wind_ff       <= nxt_wind;
			busy_ff       <= nxt_busy;
			last_err_ff   <= nxt_last_err;
			nv_req_ff     <= nxt_nv_req;
			cmd_go_ff     <= cmd_go;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign nv_req        = nv_req_ff;
	assign nv_op         = op_ff;
	assign irq           = irq_ff;

	// Storage transfer starts one cycle after the command lands and ends on the engine's done.
	sequence s_store_start;
		cmd_go_ff && state_ff == settings_cmd_pkg::st_idle && op_dec == settings_cmd_pkg::op_save;
	endsequence
	sequence s_store_end;
		state_ff == settings_cmd_pkg::st_wait_nv && nv_done && !nv_error;
	endsequence
	// A status query is decoded while idle; its snapshot lands one edge later.
	sequence s_status_go;
		cmd_go_ff && state_ff == settings_cmd_pkg::st_idle && op_dec == settings_cmd_pkg::op_status;
	endsequence

	a_save_starts_flash: assert property (@(posedge clock) disable iff (!arst_n)
		s_store_start |=> nv_req && nv_op == 3'(settings_cmd_pkg::op_save) && busy_ff)
		else $error("save command did not start a flash write");
	a_answer_after_done: assert property (@(posedge clock) disable iff (!arst_n)
		s_store_end |=> !nv_req && !busy_ff && answer_ff == cmd_word_ff)
		else $error("storage answer not given on completion");
	a_req_held_busy: assert property (@(posedge clock) disable iff (!arst_n)
		nv_req_ff && !nv_done |=> nv_req_ff && busy_ff)
		else $error("storage request dropped before done");
	a_busy_refuses_cmd: assert property (@(posedge clock) disable iff (!arst_n)
		do_write && busy_ff && aw_addr_ff == ADDR_W'(`OFS_CMD) |=> s_axi_bvalid && s_axi_bresp == `RESP_SLVERR)
		else $error("command accepted while busy");
	a_unknown_errors: assert property (@(posedge clock) disable iff (!arst_n)
		cmd_go_ff && state_ff == settings_cmd_pkg::st_idle && op_dec == settings_cmd_pkg::op_none
		|=> answer_ff == `CMD_ERROR && !busy_ff && last_err_ff)
		else $error("unknown command not answered with error");
	a_ee_lock_guard: assert property (@(posedge clock) disable iff (!arst_n)
		cmd_go_ff && state_ff == settings_cmd_pkg::st_idle && op_dec == settings_cmd_pkg::op_ee_save
		&& !ctrl_ff[`CTRL_EE_UNLOCK_BIT] |=> !nv_req && answer_ff == `CMD_ERROR)
		else $error("locked eeprom save was started");
	a_status_snapshot: assert property (@(posedge clock) disable iff (!arst_n)
		cmd_go_ff && state_ff == settings_cmd_pkg::st_idle && op_dec == settings_cmd_pkg::op_status
		|=> answer_ff == `CMD_GETS && state_word_ff[7:0] == {5'b00000, $past(backlash_active),
		$past(target_speed_reached), $past(motor_moving)})
		else $error("status answer wrong");
	a_failed_masked: assert property (@(posedge clock) disable iff (!arst_n)
		s_status_go |=> state_word_ff[15:8] == {$past(command_running),
		$past(command_failed) && !$past(command_running), $past(last_command_id)})
		else $error("command state byte wrong");
	a_wind_nibbles: assert property (@(posedge clock) disable iff (!arst_n)
		s_status_go |=> wind_ff == {2'b00, $past(winding_b_code), 2'b00, $past(winding_a_code)})
		else $error("winding byte out of layout");
	a_irq_follows: assert property (@(posedge clock) disable iff (!arst_n)
		|(status_ff & enable_ff) |=> irq)
		else $error("interrupt not raised");

endmodule : settings_cmd_ctrl
`default_nettype wire

// File: bench/nv_engine_model.sv
// Purpose: Storage engine stand-in that answers flash and stage EEPROM transfers.
// Assumes: A request is held high until this model pulses done.
// Notes: The error line toggles outside a done pulse, so it is never trusted alone.
`timescale 1ns/100ps
`default_nettype none
module nv_engine_model
(
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       nv_req,
	input  wire logic [7:0] delay,
	input  wire logic       fail,
	output var  logic       nv_done,
	output var  logic       nv_error
);
	logic [7:0] count_ff;

	// Counts the cycles of a held request, then pulses done once after the transfer time.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count_ff <= 8'h00;
			nv_done  <= 1'b0;
			nv_error <= 1'b0;
		end
		else
		begin
			nv_done  <= 1'b0;
			nv_error <= ~nv_error;
			count_ff <= 8'h00;
			if (nv_req && !nv_done && count_ff >= delay)
			begin
				nv_done  <= 1'b1;
				nv_error <= fail;
			end
			else if (nv_req && !nv_done)
				count_ff <= count_ff + 8'h01;
		end
	end
endmodule : nv_engine_model
`default_nettype wire

// File: bench/tb_settings_cmd_ctrl.sv
// Purpose: Self-checking bench for the settings-store and status command block.
// Assumes: Registers reached by single AXI4-Lite transfers, storage engine modelled.
// Notes: Ordinary commands run from a table; refusals, status and interrupts by hand.
`timescale 1ns/100ps
`default_nettype none
`include "settings_cmd_cfg.svh"
module tb_settings_cmd_ctrl;
	typedef struct {logic [31:0] cmd; logic [2:0] op; logic [31:0] ans;} row_t;
	logic        clock, arst_n, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic        awready, wready, arready, nv_req, nv_done, nv_error, irq, fail;
	logic        moving, at_speed, backlash, running, failed;
	logic [7:0]  awaddr, araddr, delay, power_code, encoder_code;
	logic [31:0] wdata, rdata, got;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp, wa_code, wb_code;
	logic [2:0]  nv_op, seen_op;
	logic [5:0]  last_id;
	int          failures, n_checks;
	row_t        rows [8];

	// Free-running 250 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	settings_cmd_ctrl u_settings_cmd_ctrl (.clock(clock), .arst_n(arst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.nv_req(nv_req), .nv_op(nv_op), .nv_done(nv_done), .nv_error(nv_error),
		.motor_moving(moving), .target_speed_reached(at_speed), .backlash_active(backlash),
		.last_command_id(last_id), .command_running(running), .command_failed(failed),
		.power_code(power_code), .encoder_code(encoder_code),
		.winding_a_code(wa_code), .winding_b_code(wb_code), .irq(irq));

	nv_engine_model u_nv_engine_model (.clock(clock), .arst_n(arst_n), .nv_req(nv_req),
		.delay(delay), .fail(fail), .nv_done(nv_done), .nv_error(nv_error));

	// Remembers which transfer the block asked for; a new command write clears it first.
	always @(posedge clock)
		if (awvalid === 1'b1 && awaddr == `OFS_CMD)
			seen_op <= 3'h0;
		else if (nv_req === 1'b1)
			seen_op <= nv_op;

	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// A wait that runs out counts as a mismatch and ends the run.
	task automatic hang();
		failures++;
		$display("MISMATCH t=%0t got=%h exp=%h (no answer)", $time, 1'b0, 1'b1);
		test_done();
	endtask : hang

	// Address and data go out together; each is dropped once taken, the response is awaited.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge clock);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (i = 0; i < 200; i++)
		begin
			@(posedge clock);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1 && !awvalid && !wvalid)
			begin
				resp = bresp;
				bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int i;
		@(posedge clock);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (i = 0; i < 200; i++)
		begin
			@(posedge clock);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1 && !arvalid)
			begin
				got = rdata;
				resp = rresp;
				rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		rd(a);
		chk(got, e);
		chk({30'h0, resp}, {30'h0, r});
	endtask : rdc

	// Polls the busy flag, as the host is meant to, before trusting the answer.
	task automatic cmd(input logic [31:0] w);
		int i;
		wr(`OFS_CMD, w, 4'hf);
		for (i = 0; i < 100; i++)
		begin
			rd(`OFS_BUSY);
			if (got[0] === 1'b0)
				return;
		end
		hang();
	endtask : cmd

	initial
	begin
		{arst_n, awvalid, wvalid, bready, arvalid, rready, fail} = '0;
		{moving, at_speed, backlash, running, failed, last_id} = '0;
		{awaddr, araddr, wdata, wstrb, power_code, encoder_code, wa_code, wb_code} = '0;
		delay = 8'h03;
		rows = '{'{`CMD_SAVE, 3'h1, `CMD_SAVE}, '{`CMD_READ, 3'h2, `CMD_READ},
			'{`CMD_SAVE_CAL, 3'h3, `CMD_SAVE_CAL}, '{`CMD_READ_CAL, 3'h4, `CMD_READ_CAL},
			'{`CMD_EE_SAVE, 3'h5, `CMD_EE_SAVE}, '{`CMD_EE_READ, 3'h6, `CMD_EE_READ},
			'{`CMD_GETS, 3'h0, `CMD_GETS}, '{32'h12345678, 3'h0, `CMD_ERROR}};
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		rdc(`OFS_ANSWER, `RST_ANSWER, `RESP_OKAY);
		rdc(`OFS_CTRL, `RST_CTRL, `RESP_OKAY);
		rdc(`OFS_IRQ_ENABLE, 32'h0, `RESP_OKAY);
		rdc(8'h24, 32'h0, `RESP_SLVERR);
		wr(8'h28, 32'h1, 4'hf);
		chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
		$display("test reset and map done");
		wr(`OFS_CTRL, 32'h1, 4'hf);
		foreach (rows[i])
		begin
			cmd(rows[i].cmd);
			chk({29'h0, seen_op}, {29'h0, rows[i].op});
			rdc(`OFS_ANSWER, rows[i].ans, `RESP_OKAY);
		end
		$display("test command table done");
		// Locked stage save, a refused second command and a failed transfer.
		wr(`OFS_CTRL, 32'h0, 4'hf);
		cmd(`CMD_EE_SAVE);
		chk({29'h0, seen_op}, 32'h0);
		rdc(`OFS_ANSWER, `CMD_ERROR, `RESP_OKAY);
		delay <= 8'h14;
		wr(`OFS_CMD, `CMD_SAVE, 4'hf);
		wr(`OFS_CMD, `CMD_READ, 4'hf);
		chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
		cmd(`CMD_READ_CAL);
		rdc(`OFS_ANSWER, `CMD_SAVE, `RESP_OKAY);
		wr(`OFS_CMD, `CMD_READ, 4'h3);
		chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
		fail <= 1'b1;
		cmd(`CMD_SAVE);
		rdc(`OFS_ANSWER, `CMD_ERROR, `RESP_OKAY);
		rdc(`OFS_BUSY, 32'h2, `RESP_OKAY);
		fail <= 1'b0;
		$display("test refusals done");
		// Status bytes: first a finished failed command, then a running one with bad codes.
		{moving, at_speed, backlash, last_id, running, failed} <= {3'b101, 6'h08, 2'b01};
		{power_code, encoder_code, wa_code, wb_code} <= {8'h04, 8'h03, 2'h3, 2'h2};
		cmd(`CMD_GETS);
		rdc(`OFS_STATE, 32'h03044805, `RESP_OKAY);
		rdc(`OFS_WIND, 32'h00000023, `RESP_OKAY);
		{moving, at_speed, backlash, last_id, running, failed} <= {3'b010, 6'h01, 2'b11};
		{power_code, encoder_code} <= {8'h02, 8'h07};
		cmd(`CMD_GETS);
		rdc(`OFS_STATE, 32'h01008102, `RESP_OKAY);
		$display("test status done");
		// Interrupts: clear all, end a motion masked, then enable, then clear.
		wr(`OFS_IRQ_CLEAR, 32'h7, 4'hf);
		running <= 1'b0;
		rdc(`OFS_IRQ_STATUS, 32'h4, `RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		wr(`OFS_IRQ_ENABLE, 32'h5, 4'hf);
		rd(`OFS_BUSY);
		chk({31'h0, irq}, 32'h1);
		wr(`OFS_IRQ_CLEAR, 32'h4, 4'hf);
		rdc(`OFS_IRQ_STATUS, 32'h0, `RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		delay <= 8'h02;
		cmd(`CMD_SAVE_CAL);
		rd(`OFS_BUSY);
		chk({31'h0, irq}, 32'h1);
		$display("test interrupts done");
		// A reset in mid-transfer drops the request and clears the answer.
		delay <= 8'h14;
		wr(`OFS_CMD, `CMD_READ, 4'hf);
		arst_n <= 1'b0;
		repeat (3) @(posedge clock);
		chk({31'h0, nv_req}, 32'h0);
		arst_n <= 1'b1;
		rdc(`OFS_ANSWER, `RST_ANSWER, `RESP_OKAY);
		$display("test second reset done");
		test_done();
	end
endmodule : tb_settings_cmd_ctrl
`default_nettype wire
